// ---- rcw_pkg.sv ----
// Constants and carrier types of the calibration, alarm and watchdog block
package rcw_pkg;

  // Register offsets
  localparam logic [3:0] ADDR_FLAGS     = 4'h0;
  localparam logic [3:0] ADDR_AL_SEC    = 4'h2;
  localparam logic [3:0] ADDR_AL_MIN    = 4'h3;
  localparam logic [3:0] ADDR_AL_HOUR   = 4'h4;
  localparam logic [3:0] ADDR_AL_DATE   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h6;
  localparam logic [3:0] ADDR_WATCHDOG  = 4'h7;
  localparam logic [3:0] ADDR_CALIB     = 4'h8;

  // Flags and control fields
  localparam int FLAG_WDT_BIT    = 7;
  localparam int FLAG_ALARM_BIT  = 6;
  localparam int FLAG_CALTEST_BIT = 2;
  localparam int FLAG_UNLOCK_BIT = 1;
  localparam int FLAG_HOLD_BIT   = 0;
  // Interrupt enable fields
  localparam int IRQ_WDT_BIT     = 7;
  localparam int IRQ_ALARM_BIT   = 6;
  // Watchdog fields
  localparam int WD_STROBE_BIT   = 7;
  localparam int WD_LOCK_BIT     = 6;
  localparam int WD_VAL_MSB      = 5;
  // Calibration fields
  localparam int CAL_SIGN_BIT    = 5;
  localparam int CAL_MAG_MSB     = 4;
  // Match-exclude bit of every alarm field
  localparam int AL_MATCH_BIT    = 7;

  // Reset values
  localparam logic [7:0] RST_WATCHDOG = 8'h00;
  localparam logic [7:0] RST_CALIB    = 8'h00;
  localparam logic [7:0] RST_ALARM    = 8'h80;
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;

  // Oscillator divider figures, in oscillator cycles, seconds and minutes
  localparam logic [15:0] OSC_PER_SEC    = 16'h8000;
  localparam logic [15:0] CAL_SHORTEN    = 16'h0080;
  localparam logic [15:0] CAL_LENGTHEN   = 16'h0100;
  localparam logic [5:0]  SEC_PER_MIN    = 6'h3c;
  localparam logic [5:0]  CAL_CYCLE_MIN  = 6'h3f;
  localparam logic [5:0]  CAL_MAX_MIN    = 6'h3e;
  // 512 Hz test toggles every 32 oscillator cycles; 32 Hz tick every 1024
  localparam logic [4:0]  TEST_HALF_LAST = 5'h1f;
  localparam logic [9:0]  WDT_TICK_LAST  = 10'h3ff;

  typedef struct packed {
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rcw_time_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcw_req_type;

endpackage

// ---- rcw_core.sv ----
// Oscillator calibration, date/time alarm and watchdog of the real-time clock
// What this block does
// - Magnitude is calibration bits four to zero
// - Bit five set speeds up, clear slows
// - 64-minute cycle, one second adjusted per minute
// - Only first two-times-magnitude minutes are adjusted
// - Test bit toggles interrupt output at 512 Hz
// - Test output ignores calibration value
// - Test and hold flags writable only while unlock bit set
// - Alarm match sets flag, interrupt if enabled
// - Per-field match bit, zero includes field
// - All ones disables, all zeros exact match
// - Reading flags clears watchdog and alarm flags
// - Alarm values take effect when unlock clears
// - Watchdog counts 32 Hz oscillator ticks only
// - Load at reset, reload on strobe write
// - Count zero sets flag, interrupt if enabled
// - Timeout field ignored by writes with lock bit set
// - Timeout value zero disables the watchdog
// - Flags read clears watchdog flag and interrupt
// - Test output overrides all interrupt sources
// - Unlock bit in flags; clearing commits values
module rcw_core
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  osc_in,
  input  wire rcw_pkg::rcw_time_type now_time,
  input  wire rcw_pkg::rcw_req_type  req,
  output logic [7:0]                 rdata_q,
  output logic                       sec_tick_q,
  output logic                       int_q
);
  import rcw_pkg::*;

  logic         osc_s1_q;
  logic         osc_s2_q;
  logic         osc_s3_q;
  logic         osc_tick;
  logic [9:0]   raw_q;
  logic         test_wave_q;
  logic         wdt_tick;
  logic [15:0]  div_q;
  logic [15:0]  sec_len;
  logic [5:0]   sec_in_min_q;
  logic [5:0]   min_in_cyc_q;
  logic         adj_minute;
  logic [7:0]   flags_q;
  logic [7:0]   irq_en_q;
  logic [7:0]   wd_reg_q;
  logic [7:0]   cal_stage_q;
  logic [7:0]   cal_q;
  rcw_time_type al_stage_q;
  rcw_time_type al_q;
  logic [5:0]   wd_cnt_q;
  logic         wd_to_ev;
  logic         al_ev;
  logic         match_now;
  logic         match_prev_q;
  logic [3:0]   excl;
  logic [3:0]   field_hit;
  logic         unlock;
  logic         unlock_fall;
  logic         wr_flags;
  logic         rd_flags;
  logic         wd_strobe;

  assign unlock   = flags_q[FLAG_UNLOCK_BIT];
  assign wr_flags = req.wr && req.addr == ADDR_FLAGS;
  assign rd_flags = req.rd && req.addr == ADDR_FLAGS;
  assign wd_strobe = req.wr && req.addr == ADDR_WATCHDOG && req.wdata[WD_STROBE_BIT];
  assign unlock_fall = wr_flags && unlock && !req.wdata[FLAG_UNLOCK_BIT];

  // Oscillator pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // A stopped oscillator yields no ticks, so prescaler, seconds divider and watchdog freeze
  assign osc_tick = osc_s2_q && !osc_s3_q;

  // Uncorrected prescaler feeding the test output and the watchdog
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      raw_q       <= 10'h000;
      test_wave_q <= 1'b0;
    end
    else if (osc_tick)
    begin
      raw_q <= raw_q + 10'h001;
      if (raw_q[4:0] == TEST_HALF_LAST)
      begin
        test_wave_q <= !test_wave_q;
      end
    end
  end

  assign wdt_tick = osc_tick && raw_q[9:0] == WDT_TICK_LAST;

  // Calibrated seconds divider
  assign adj_minute = min_in_cyc_q < CAL_MAX_MIN
                   && min_in_cyc_q < {cal_q[CAL_MAG_MSB:0], 1'b0};

  always_comb
  begin
    sec_len = OSC_PER_SEC;
    if (adj_minute && sec_in_min_q == SEC_PER_MIN - 6'h01)
    begin
      sec_len = cal_q[CAL_SIGN_BIT] ? OSC_PER_SEC - CAL_SHORTEN
                                    : OSC_PER_SEC + CAL_LENGTHEN;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q        <= 16'h0000;
      sec_in_min_q <= 6'h00;
      min_in_cyc_q <= 6'h00;
      sec_tick_q   <= 1'b0;
    end
    else
    begin
      sec_tick_q <= 1'b0;
      if (osc_tick)
      begin
        if (div_q >= sec_len - 16'h0001)
        begin
          div_q      <= 16'h0000;
          sec_tick_q <= 1'b1;
          if (sec_in_min_q == SEC_PER_MIN - 6'h01)
          begin
            sec_in_min_q <= 6'h00;
            min_in_cyc_q <= (min_in_cyc_q == CAL_CYCLE_MIN) ? 6'h00
                                                            : min_in_cyc_q + 6'h01;
          end
          else
          begin
            sec_in_min_q <= sec_in_min_q + 6'h01;
          end
        end
        else
        begin
          div_q <= div_q + 16'h0001;
        end
      end
    end
  end

  // Staging of alarm and calibration writes, committed when unlock clears
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      al_stage_q  <= {4{RST_ALARM}};
      al_q        <= {4{RST_ALARM}};
      cal_stage_q <= RST_CALIB;
      cal_q       <= RST_CALIB;
      irq_en_q    <= RST_IRQ_EN;
    end
    else
    begin
      if (req.wr && unlock)
      begin
        case (req.addr)
          ADDR_AL_SEC:  al_stage_q.seconds <= req.wdata;
          ADDR_AL_MIN:  al_stage_q.minutes <= req.wdata;
          ADDR_AL_HOUR: al_stage_q.hours   <= req.wdata;
          ADDR_AL_DATE: al_stage_q.date    <= req.wdata;
          ADDR_IRQ_EN:  irq_en_q           <= req.wdata;
          ADDR_CALIB:   cal_stage_q        <= req.wdata;
          default:      ;
        endcase
      end
      if (unlock_fall)
      begin
        al_q  <= al_stage_q;
        cal_q <= cal_stage_q;
      end
    end
  end

  // Alarm comparator; a field whose match bit is one is left out
  for (genvar f = 0; f < 4; f++)
  begin : g_field
    assign excl[f]      = al_q[8 * f + AL_MATCH_BIT];
    assign field_hit[f] = excl[f] || al_q[8 * f +: 7] == now_time[8 * f +: 7];
  end

  assign match_now = excl != 4'hf && &field_hit;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      match_prev_q <= 1'b0;
    end
    else
    begin
      match_prev_q <= match_now;
    end
  end

  // One event per entry into a matching time, not one per cycle
  assign al_ev = match_now && !match_prev_q;

  // Watchdog register and down counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wd_reg_q <= RST_WATCHDOG;
    end
    else if (req.wr && req.addr == ADDR_WATCHDOG)
    begin
      wd_reg_q[WD_LOCK_BIT] <= req.wdata[WD_LOCK_BIT];
      if (!req.wdata[WD_LOCK_BIT])
      begin
        wd_reg_q[WD_VAL_MSB:0] <= req.wdata[WD_VAL_MSB:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wd_cnt_q <= RST_WATCHDOG[WD_VAL_MSB:0];
    end
    else if (wd_strobe)
    begin
      wd_cnt_q <= req.wdata[WD_LOCK_BIT] ? wd_reg_q[WD_VAL_MSB:0]
                                         : req.wdata[WD_VAL_MSB:0];
    end
    else if (wdt_tick && wd_cnt_q != 6'h00 && wd_reg_q[WD_VAL_MSB:0] != 6'h00)
    begin
      wd_cnt_q <= wd_cnt_q - 6'h01;
    end
  end

  assign wd_to_ev = wdt_tick && !wd_strobe && wd_cnt_q == 6'h01
                 && wd_reg_q[WD_VAL_MSB:0] != 6'h00;

  // Flags register; an event in the clearing cycle still sets its flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= 8'h00;
    end
    else
    begin
      if (wr_flags)
      begin
        flags_q[FLAG_UNLOCK_BIT] <= req.wdata[FLAG_UNLOCK_BIT];
        if (unlock)
        begin
          flags_q[FLAG_CALTEST_BIT] <= req.wdata[FLAG_CALTEST_BIT];
          flags_q[FLAG_HOLD_BIT]    <= req.wdata[FLAG_HOLD_BIT];
        end
      end
      if (rd_flags)
      begin
        flags_q[FLAG_WDT_BIT]   <= 1'b0;
        flags_q[FLAG_ALARM_BIT] <= 1'b0;
      end
      if (wd_to_ev)
      begin
        flags_q[FLAG_WDT_BIT] <= 1'b1;
      end
      if (al_ev)
      begin
        flags_q[FLAG_ALARM_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt output; test wave has the highest priority
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_q <= 1'b0;
    end
    else if (flags_q[FLAG_CALTEST_BIT])
    begin
      int_q <= test_wave_q;
    end
    else
    begin
      int_q <= (flags_q[FLAG_WDT_BIT] && irq_en_q[IRQ_WDT_BIT])
            || (flags_q[FLAG_ALARM_BIT] && irq_en_q[IRQ_ALARM_BIT]);
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (req.rd)
    begin
      case (req.addr)
        ADDR_FLAGS:    rdata_q <= flags_q;
        ADDR_AL_SEC:   rdata_q <= al_stage_q.seconds;
        ADDR_AL_MIN:   rdata_q <= al_stage_q.minutes;
        ADDR_AL_HOUR:  rdata_q <= al_stage_q.hours;
        ADDR_AL_DATE:  rdata_q <= al_stage_q.date;
        ADDR_IRQ_EN:   rdata_q <= irq_en_q;
        ADDR_WATCHDOG: rdata_q <= {2'b00, wd_reg_q[WD_VAL_MSB:0]};
        ADDR_CALIB:    rdata_q <= cal_stage_q;
        default:       rdata_q <= 8'h00;
      endcase
    end
  end

endmodule // rcw_core

// ---- rcw_core_sva.sv ----
// Port assertions of the calibration, alarm and watchdog block
module rcw_core_sva
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  osc_in,
  input wire rcw_pkg::rcw_time_type now_time,
  input wire rcw_pkg::rcw_req_type  req,
  input wire logic [7:0]            rdata_q,
  input wire logic                  sec_tick_q,
  input wire logic                  int_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcw_pkg::*;
  logic       unlock_q;
  logic       cal_seen_q;
  logic [5:0] wd_val_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Sticky until reset, so the test wave never trips the interrupt checks
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      unlock_q   <= 1'b0;
      cal_seen_q <= 1'b0;
    end
    else if (req.wr && req.addr == ADDR_FLAGS)
    begin
      unlock_q <= req.wdata[FLAG_UNLOCK_BIT];
      if (unlock_q && req.wdata[FLAG_CALTEST_BIT])
        cal_seen_q <= 1'b1;
    end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      wd_val_q <= 6'h00;
    else if (req.wr && req.addr == ADDR_WATCHDOG && !req.wdata[WD_LOCK_BIT])
      wd_val_q <= req.wdata[5:0];
  sequence s_flags_rd;
    req.rd && req.addr == ADDR_FLAGS;
  endsequence
  property p_flags_clear;
    s_flags_rd ##1 s_flags_rd |=> rdata_q[7:6] == 2'h0;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags kept");
  property p_int_drop;
    s_flags_rd ##0 !cal_seen_q |=> ##1 !int_q;
  endproperty
  a_int_drop: assert property (p_int_drop) else $error("int kept");
  property p_int_fall;
    $fell(int_q) && !cal_seen_q |-> $past(req.rd, 2) && $past(req.addr, 2) == ADDR_FLAGS;
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("int fell alone");
  property p_wd_value;
    req.rd && req.addr == ADDR_WATCHDOG |=> rdata_q == {2'h0, $past(wd_val_q)};
  endproperty
  a_wd_value: assert property (p_wd_value) else $error("timeout value");
  property p_unlock_rb;
    s_flags_rd |=> rdata_q[FLAG_UNLOCK_BIT] == $past(unlock_q);
  endproperty
  a_unlock_rb: assert property (p_unlock_rb) else $error("unlock bit");
  property p_cal_locked;
    s_flags_rd ##0 !cal_seen_q |=> !rdata_q[FLAG_CALTEST_BIT];
  endproperty
  a_cal_locked: assert property (p_cal_locked) else $error("test bit");
  property p_rd_stand;
    !req.rd |=> $stable(rdata_q);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_unmapped;
    req.rd && req.addr > ADDR_CALIB |=> rdata_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule // rcw_core_sva

bind rcw_core rcw_core_sva rcw_core_sva_i
(
  .clk        (clk),
  .rst        (rst),
  .osc_in     (osc_in),
  .now_time   (now_time),
  .req        (req),
  .rdata_q    (rdata_q),
  .sec_tick_q (sec_tick_q),
  .int_q      (int_q)
);

// ---- rcw_host.sv ----
// Host microcontroller model on the register request port
module rcw_host
(
  input  wire logic           clk,
  input  wire logic [7:0]     rdata_q,
  output rcw_pkg::rcw_req_type req
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcw_pkg::*;
  initial req = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= {a, d, 2'b10};
    @(negedge clk);
    req <= '0;
  endtask
  // Always two reads back to back, so the second shows what the first cleared
  task automatic rd(input logic [3:0] a, output logic [7:0] d1, output logic [7:0] d2);
    @(negedge clk);
    req <= {a, 8'h00, 2'b01};
    @(negedge clk);
    d1 = rdata_q;
    @(negedge clk);
    d2 = rdata_q;
    req <= '0;
  endtask
  task automatic arm(input logic [6:0] s, input logic [7:0] en);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_AL_SEC, {1'b0, s});
    wr(ADDR_IRQ_EN, en);
  endtask
  task automatic commit();
    wr(ADDR_FLAGS, 8'h00);
  endtask
endmodule // rcw_host

// ---- tb.sv ----
// Self-checking bench of the calibration, alarm and watchdog block
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcw_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         osc_in = 1'b0;
  rcw_time_type now_time = '0;
  rcw_req_type  req;
  logic [7:0]   rdata_q;
  logic         sec_tick_q;
  logic         int_q;
  int           mismatches = 0;
  int           samples_checked = 0;
  int           n;
  logic [31:0]  seed = 32'h7;
  logic [6:0]   s;
  logic [7:0]   d1, d2;
  logic [7:0]   wv [2] = '{8'h82, 8'hc0};
  rcw_host rcw_host_i (.clk(clk), .rdata_q(rdata_q), .req(req));
  rcw_core rcw_core_i (.clk(clk), .rst(rst), .osc_in(osc_in), .now_time(now_time), .req(req),
                       .rdata_q(rdata_q), .sec_tick_q(sec_tick_q), .int_q(int_q));
  initial forever #20 clk = ~clk;
  // Oscillator sped up and free of clk phase, so watchdog ticks fit the run
  initial forever #83 osc_in = ~osc_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Clocks per watchdog tick: 1024 oscillator edges of 166 ns
  function automatic int wd_win(input int v);
    return v * 1024 * 166 / 40;
  endfunction
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rcw_host_i.rd(a, d1, d2);
    `CHK("reg", e, d1)
  endtask
  task automatic wait_int(input logic v, input int lim);
    n = 0;
    while (int_q !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #2ms;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rchk(ADDR_FLAGS, 8'h00);
    rchk(ADDR_AL_SEC, RST_ALARM);
    rchk(ADDR_WATCHDOG, 8'h00);
    rchk(4'hc, 8'h00);
    rcw_host_i.wr(ADDR_FLAGS, 8'h04);
    rchk(ADDR_FLAGS, 8'h00);
    seed = xs(seed);
    s = seed[6:0];
    now_time = xs(seed);
    now_time.seconds = {1'b0, ~s};
    rcw_host_i.arm(s, 8'h40);
    now_time.seconds[6:0] = s;
    repeat (4) @(negedge clk);
    `CHK("early alarm", 1'b0, int_q)
    now_time.seconds[6:0] = ~s;
    rcw_host_i.commit();
    now_time.seconds[6:0] = s;
    wait_int(1'b1, 8);
    `CHK("alarm int", 1'b1, int_q)
    rchk(ADDR_FLAGS, 8'h40);
    `CHK("int clear", 1'b0, int_q)
    now_time.seconds[6:0] = ~s;
    rcw_host_i.arm(s, 8'h80);
    rcw_host_i.commit();
    foreach (wv[i])
    begin
      rcw_host_i.wr(ADDR_WATCHDOG, wv[i]);
      rcw_host_i.wr(ADDR_WATCHDOG, 8'hc5);
      rchk(ADDR_WATCHDOG, 8'h02);
      wait_int(1'b1, wd_win(2) + 8);
      `CHK("wd time", 1'b1, int_q && n + 8 > wd_win(1))
      rchk(ADDR_FLAGS, 8'h80);
    end
    rcw_host_i.wr(ADDR_WATCHDOG, 8'h82);
    rcw_host_i.wr(ADDR_WATCHDOG, 8'h00);
    wait_int(1'b1, wd_win(3));
    `CHK("wd off", 1'b0, int_q)
    rcw_host_i.wr(ADDR_FLAGS, 8'h02);
    rcw_host_i.wr(ADDR_CALIB, 8'h3f);
    rchk(ADDR_CALIB, 8'h3f);
    rcw_host_i.wr(ADDR_FLAGS, 8'h04);
    wait_int(1'b1, 400);
    wait_int(1'b0, 400);
    wait_int(1'b1, 400);
    `CHK("test wave", 1'b1, n > 129 && n < 137)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK("rst int", 1'b0, int_q)
    `CHK("rst tick", 1'b0, sec_tick_q)
    rchk(ADDR_CALIB, RST_CALIB);
    final_report();
  end
endmodule // tb
